// [logic/supervisor_pkg.sv]
// Shared constants and carrier types for the reset supervisor
package supervisor_pkg;
	// Clock rate
	localparam int CLK_HZ = 50000000;
	localparam int CLK_PERIOD_NS = 20;
	// Reset hold period options, in microseconds
	localparam int HOLD_OPT0_US = 1000;
	localparam int HOLD_OPT1_US = 20000;
	localparam int HOLD_OPT2_US = 140000;
	localparam int HOLD_OPT3_US = 1120000;
	// Kick timeout period options, in microseconds
	localparam int KICK_OPT0_US = 6300;
	localparam int KICK_OPT1_US = 102000;
	localparam int KICK_OPT2_US = 1600000;
	localparam int KICK_OPT3_US = 25600000;
	// Internal service at seven eighths of the kick period
	localparam int SERVICE_NUM = 7;
	localparam int SERVICE_DEN = 8;
	// Manual reset glitch rejection, least time in ns
	localparam int GLITCH_NS = 100;
	localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Pullup one-shot, longest time in ns
	localparam int ONESHOT_NS = 2000;
	localparam int ONESHOT_CYCLES = ONESHOT_NS / CLK_PERIOD_NS;
	// Counter widths
	localparam int CNT_W = 32;
	localparam int SHORT_W = 8;
	// Default option selection
	localparam logic [1:0] HOLD_SEL_DEFAULT = 2'h2;
	localparam logic [1:0] KICK_SEL_DEFAULT = 2'h1;

	// Synchronised pin levels
	typedef struct packed {
		logic manual_n;
		logic kick;
		logic kick_driven;
		logic undervoltage;
		logic line_above_pth;
		logic line_above_high;
		logic line_in;
	} pins_type;

	// Reset output group
	typedef struct packed {
		logic reset_n;
		logic reset;
		logic line_oe;
		logic pullup_en;
	} reset_out_type;

	// Cycle count from microseconds, whole cycles per microsecond, exact at 50 MHz
	function automatic logic [CNT_W-1:0] us_to_cycles(input int unsigned us);
		longint unsigned c;
		c = longint'(us) * longint'(CLK_HZ / 1000000);
		return c[CNT_W-1:0];
	endfunction
endpackage

// [logic/pin_sync.sv]
// Two-stage synchronisers for the supervisor input pins
`timescale 1ns/1ps
module pin_sync
	import supervisor_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Raw and synchronised pins
	input wire supervisor_pkg::pins_type pins_raw,
	output supervisor_pkg::pins_type pins_sync
);
	import supervisor_pkg::*;
	localparam int W = $bits(pins_type);
	localparam logic [W-1:0] IDLE = {1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	logic [W-1:0] first_reg;
	logic [W-1:0] first_next;
	logic [W-1:0] second_reg;
	logic [W-1:0] second_next;

	// Next values of both stages
	always_comb begin
		first_next = pins_raw;
		second_next = first_reg;
	end

	// Stage registers, idle levels at reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			first_reg <= IDLE;
			second_reg <= IDLE;
		end else begin
			first_reg <= first_next;
			second_reg <= second_next;
		end
	end

	assign pins_sync = second_reg;
endmodule

// [logic/pullup_ctrl.sv]
// Edge flip-flop and one-shot that steer the active pullup
`timescale 1ns/1ps
module pullup_ctrl
	import supervisor_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Line comparator levels and own drive
	input wire logic above_pth,
	input wire logic above_high,
	input wire logic driving_low,
	// Pullup enable
	output logic pullup_en
);
	import supervisor_pkg::*;
	logic edge_reg;
	logic edge_next;
	logic [SHORT_W-1:0] shot_reg;
	logic [SHORT_W-1:0] shot_next;
	logic en_reg;
	logic en_next;

	// Arm on low line, fire on release, stop at high level or timeout
	always_comb begin
		edge_next = edge_reg;
		shot_next = shot_reg;
		en_next = 1'b0;
		if (!above_pth) begin
			edge_next = 1'b1;
			shot_next = SHORT_W'(ONESHOT_CYCLES);
		end else if (edge_reg && !driving_low) begin
			if (above_high || shot_reg == '0) begin
				edge_next = 1'b0;
			end else begin
				en_next = 1'b1;
				shot_next = shot_reg - SHORT_W'(1);
			end
		end
	end

	// State registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			edge_reg <= 1'b0;
			shot_reg <= '0;
			en_reg <= 1'b0;
		end else begin
			edge_reg <= edge_next;
			shot_reg <= shot_next;
			en_reg <= en_next;
		end
	end

	assign pullup_en = en_reg;
endmodule

// [logic/supervisor_reset_watchdog.sv]
// Reset supervisor with manual reset, watchdog and bidirectional line
// Summary of operation
// - Reset held while manual reset input is low.
// - After manual reset rises, hold reset one hold period more.
// - Reset when a driven kick input stays constant for a whole kick period.
// - Kick timer cleared by reset and by any edge of a driven kick input.
// - Reset while undervoltage; release after supply good plus hold period.
// - After hold period ends, release reset and restart kick timer.
// - Active-high reset output is always the inverse of active-low.
// - Another party pulling the shared line low causes a reset once the line has been seen high since release.
// - Active pullup only speeds the line's rise after a low; the resistor holds it high.
// - Line below pullup threshold sets the edge flip-flop.
// - Pullup on during release until high level or 2us one-shot expires.
// - Kick timer held cleared for as long as reset is asserted.
// - Undriven kick input is serviced internally at seven eighths period.
// - Manual reset pulses shorter than 100ns are ignored.
`timescale 1ns/1ps
module supervisor_reset_watchdog
	import supervisor_pkg::*;
#(
	parameter logic [1:0] HOLD_SEL = supervisor_pkg::HOLD_SEL_DEFAULT,
	parameter logic [1:0] KICK_SEL = supervisor_pkg::KICK_SEL_DEFAULT,
	parameter logic [31:0] HOLD_CYCLES = 32'h0,
	parameter logic [31:0] KICK_CYCLES = 32'h0
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Supply and line comparators
	input wire logic undervoltage,
	input wire logic line_above_pth,
	input wire logic line_above_high,
	// Manual reset and watchdog kick
	input wire logic manual_reset_n,
	input wire logic watchdog_kick_input,
	input wire logic kick_driven,
	// Bidirectional reset line
	input wire logic reset_line_in,
	output logic reset_line_out,
	output logic reset_line_oe,
	// Push-pull reset outputs and pullup
	output logic reset_n_out,
	output logic reset_out,
	output logic pullup_en
);
	import supervisor_pkg::*;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_HOLD = 2'b10
	} state_type;

	// Option decoding, used for both periods
	function automatic logic [CNT_W-1:0] pick(input logic [1:0] sel, input int o0,
		input int o1, input int o2, input int o3);
		case (sel)
			2'h0: pick = us_to_cycles(o0);
			2'h1: pick = us_to_cycles(o1);
			2'h2: pick = us_to_cycles(o2);
			default: pick = us_to_cycles(o3);
		endcase
	endfunction

	// Any state but run holds the reset asserted
	function automatic logic in_reset(input state_type s);
		return s != ST_RUN;
	endfunction

	// Periods, overridable for short simulation
	localparam logic [CNT_W-1:0] HOLD_N = (HOLD_CYCLES != 0) ? HOLD_CYCLES :
		pick(HOLD_SEL, HOLD_OPT0_US, HOLD_OPT1_US, HOLD_OPT2_US, HOLD_OPT3_US);
	localparam logic [CNT_W-1:0] KICK_N = (KICK_CYCLES != 0) ? KICK_CYCLES :
		pick(KICK_SEL, KICK_OPT0_US, KICK_OPT1_US, KICK_OPT2_US, KICK_OPT3_US);
	localparam logic [CNT_W-1:0] SERVICE_N = CNT_W'((64'(KICK_N) * SERVICE_NUM) / SERVICE_DEN);

	// Gathered and synchronised pins
	pins_type raw;
	pins_type syn;

	// Sequencer state and hold counter
	state_type state_reg;
	state_type state_next;
	logic [CNT_W-1:0] hold_reg;
	logic [CNT_W-1:0] hold_next;
	logic hold_done;
	logic drive_reg;
	logic drive_next;

	// Kick timer
	logic [CNT_W-1:0] kick_reg;
	logic [CNT_W-1:0] kick_next;
	logic kick_prev_reg;
	logic kick_prev_next;
	logic kick_edge;
	logic kick_expired;
	logic service_due;

	// Manual reset filter and causes
	logic [SHORT_W-1:0] glitch_reg;
	logic [SHORT_W-1:0] glitch_next;
	logic manual_low;
	logic line_low_ext;
	logic cause;

	// Line release tracking
	logic line_seen_reg;
	logic line_seen_next;

	// Pullup request from the edge logic
	logic pullup_int;

	// Output register
	reset_out_type out_reg;
	reset_out_type out_next;

	// Gather raw pins
	always_comb begin
		raw.manual_n = manual_reset_n;
		raw.kick = watchdog_kick_input;
		raw.kick_driven = kick_driven;
		raw.undervoltage = undervoltage;
		raw.line_above_pth = line_above_pth;
		raw.line_above_high = line_above_high;
		raw.line_in = reset_line_in;
	end

	pin_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pins_raw(raw),
		.pins_sync(syn)
	);

	pullup_ctrl u_pullup (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.above_pth(syn.line_above_pth),
		.above_high(syn.line_above_high),
		.driving_low(drive_reg),
		.pullup_en(pullup_int)
	);

	// Manual reset glitch filter, short low pulses never reach the count
	always_comb begin
		glitch_next = glitch_reg;
		if (syn.manual_n) begin
			glitch_next = '0;
		end else if (glitch_reg != SHORT_W'(GLITCH_CYCLES)) begin
			glitch_next = glitch_reg + SHORT_W'(1);
		end
	end

	// Cause combination; a low line is foreign only once seen high since release
	always_comb begin
		manual_low = (glitch_reg == SHORT_W'(GLITCH_CYCLES));
		line_low_ext = !syn.line_in && !drive_reg && line_seen_reg;
		cause = manual_low || syn.undervoltage || line_low_ext;
	end

	// Release tracking; the synchronised line lags our release by two cycles
	always_comb begin
		line_seen_next = line_seen_reg;
		if (drive_next) begin
			line_seen_next = 1'b0;
		end else if (syn.line_in) begin
			line_seen_next = 1'b1;
		end
	end

	// Kick edge detection; edges of an undriven input are ignored
	always_comb begin
		kick_prev_next = syn.kick;
		kick_edge = syn.kick_driven && (syn.kick != kick_prev_reg);
		service_due = !syn.kick_driven && (kick_reg >= SERVICE_N - CNT_W'(1));
	end

	// Kick timer; only the internal service keeps an undriven input from expiring
	always_comb begin
		kick_expired = (kick_reg >= KICK_N - CNT_W'(1));
		kick_next = kick_reg + CNT_W'(1);
		if (in_reset(state_reg) || kick_edge) begin
			kick_next = '0;
		end else if (service_due) begin
			kick_next = '0;
		end
	end

	// Reset sequencer
	always_comb begin
		state_next = state_reg;
		hold_next = hold_reg;
		case (state_reg)
			ST_RUN: begin
				if (cause || kick_expired) begin
					state_next = cause ? ST_ACTIVE : ST_HOLD;
					hold_next = '0;
				end
			end
			ST_ACTIVE: begin
				hold_next = '0;
				if (!cause) begin
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cause) begin
					state_next = ST_ACTIVE;
					hold_next = '0;
				end else if (hold_done) begin
					state_next = ST_RUN;
				end else begin
					hold_next = hold_reg + CNT_W'(1);
				end
			end
			default: begin
				state_next = ST_ACTIVE;
				hold_next = '0;
			end
		endcase
	end

	// Hold period end; the exit edge itself is the last held cycle
	always_comb begin
		hold_done = (hold_reg >= HOLD_N - CNT_W'(1));
	end

	// Output decode from the next state, so every pin moves with the state
	always_comb begin
		drive_next = in_reset(state_next);
		out_next.reset_n = !drive_next;
		out_next.reset = drive_next;
		out_next.line_oe = drive_next;
		out_next.pullup_en = pullup_int && !drive_next;
	end

	// Glitch filter register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			glitch_reg <= '0;
		end else begin
			glitch_reg <= glitch_next;
		end
	end

	// Kick timer and previous kick level
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			kick_reg <= '0;
			kick_prev_reg <= 1'b0;
		end else begin
			kick_reg <= kick_next;
			kick_prev_reg <= kick_prev_next;
		end
	end

	// Sequencer state; reset starts active so a full hold period follows
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg <= ST_ACTIVE;
			hold_reg <= '0;
			drive_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			hold_reg <= hold_next;
			drive_reg <= drive_next;
		end
	end

	// Release tracking flag
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			line_seen_reg <= 1'b0;
		end else begin
			line_seen_reg <= line_seen_next;
		end
	end

	// Output register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			out_reg <= '{reset_n: 1'b0, reset: 1'b1, line_oe: 1'b1, pullup_en: 1'b0};
		end else begin
			out_reg <= out_next;
		end
	end

	// Open-drain data is always low; only the enable moves
	assign reset_line_out = 1'b0;

	// Push-pull pins and pullup straight from the output register
	assign reset_n_out = out_reg.reset_n;
	assign reset_out = out_reg.reset;
	assign reset_line_oe = out_reg.line_oe;
	assign pullup_en = out_reg.pullup_en;
endmodule

// [testbench/supervisor_chk.sv]
// Assertion checker for the reset supervisor ports
`timescale 1ns/1ps
module supervisor_chk
	import supervisor_pkg::*;
#(
	parameter logic [31:0] HOLD_CYCLES = 32'h0,
	parameter logic [31:0] KICK_CYCLES = 32'h0
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Causes
	input wire logic undervoltage,
	input wire logic manual_reset_n,
	input wire logic watchdog_kick_input,
	input wire logic kick_driven,
	input wire logic reset_line_in,
	// Outputs
	input wire logic reset_line_oe,
	input wire logic reset_n_out,
	input wire logic reset_out,
	input wire logic pullup_en
);
	logic [31:0] quiet_reg, quiet_next, kick_reg, kick_next, pu_reg, pu_next;
	logic kick_d_reg;
	// Cycles since an outside cause, since a kick edge, and of pullup drive
	always_comb begin
		quiet_next = quiet_reg + 32'h1;
		if (!manual_reset_n || undervoltage || (!reset_line_in && !reset_line_oe))
			quiet_next = 32'h0;
		kick_next = kick_reg + 32'h1;
		if (!reset_n_out || !kick_driven || watchdog_kick_input != kick_d_reg)
			kick_next = 32'h0;
		pu_next = pullup_en ? pu_reg + 32'h1 : 32'h0;
	end
	// Helper registers
	always_ff @(posedge clk_sys) begin
		quiet_reg <= rst_n ? quiet_next : 32'h0;
		kick_reg <= rst_n ? kick_next : 32'h0;
		pu_reg <= rst_n ? pu_next : 32'h0;
		kick_d_reg <= watchdog_kick_input;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	inv_out_a: assert property (reset_out == !reset_n_out)
		else $error("high reset not inverse of low reset");
	manual_on_a: assert property ((!manual_reset_n)[*8] |-> ##[0:3] !reset_n_out)
		else $error("manual reset not asserted");
	uv_on_a: assert property (undervoltage[*3] |-> ##[0:2] !reset_n_out)
		else $error("undervoltage reset not asserted");
	hold_time_a: assert property ($rose(reset_n_out) |-> quiet_reg >= HOLD_CYCLES)
		else $error("reset released before hold period");
	kick_bound_a: assert property (kick_reg < KICK_CYCLES + 32'h8)
		else $error("watchdog timeout missed");
	kick_early_a: assert property ($fell(reset_n_out) |->
		quiet_reg < 32'h10 || $past(kick_reg) >= KICK_CYCLES - 32'h2)
		else $error("reset without cause");
	line_drive_a: assert property (reset_line_oe == !reset_n_out)
		else $error("line drive differs from reset");
	pu_off_a: assert property (pullup_en |-> !reset_line_oe)
		else $error("pullup while pulling low");
	pu_shot_a: assert property (pu_reg < ONESHOT_CYCLES + 2)
		else $error("pullup one-shot too long");
	cover property ($fell(reset_n_out) && kick_driven && manual_reset_n);
	cover property ($rose(pullup_en));
	cover property ($rose(reset_n_out));
endmodule
bind supervisor_reset_watchdog supervisor_chk #(
	.HOLD_CYCLES(HOLD_CYCLES), .KICK_CYCLES(KICK_CYCLES)) i_supervisor_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .undervoltage(undervoltage),
	.manual_reset_n(manual_reset_n), .watchdog_kick_input(watchdog_kick_input),
	.kick_driven(kick_driven), .reset_line_in(reset_line_in),
	.reset_line_oe(reset_line_oe), .reset_n_out(reset_n_out),
	.reset_out(reset_out), .pullup_en(pullup_en));

// [testbench/host_model.sv]
// Processor side: shared reset wire, resistor pullup and rise comparators
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic clk_sys,
	// Line drivers
	input wire logic dev_oe,
	input wire logic host_pull,
	input wire logic pullup_en,
	// Line level and comparators
	output logic line_in,
	output logic above_pth,
	output logic above_high
);
	logic [7:0] rise_reg = 8'h40;
	// Any low driver wins; resistor pulls high otherwise
	assign line_in = !(dev_oe || host_pull);
	assign above_pth = line_in;
	assign above_high = line_in && rise_reg >= 8'h3c;
	// Slow resistor rise, fast once the active pullup helps
	always @(negedge clk_sys) begin
		if (!line_in)
			rise_reg <= 8'h0;
		else if (pullup_en)
			rise_reg <= 8'h40;
		else if (rise_reg < 8'h40)
			rise_reg <= rise_reg + 8'h1;
	end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the reset supervisor
`timescale 1ns/1ps
module tb_top;
	import supervisor_pkg::*;
	localparam int HOLD = 50;
	localparam int KICK = 200;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic undervoltage = 1'b0;
	logic manual_n = 1'b1;
	logic kick = 1'b0;
	logic kick_driven = 1'b0;
	logic host_pull = 1'b0;
	logic line_in, above_pth, above_high, line_oe, rst_lo, rst_hi, pullup_en, seen;
	int fails = 0;
	int comparisons = 0;
	int n;
	supervisor_reset_watchdog #(.HOLD_CYCLES(32'h32), .KICK_CYCLES(32'hc8))
		i_supervisor_reset_watchdog (.clk_sys(clk_sys), .rst_n(rst_n),
		.undervoltage(undervoltage), .line_above_pth(above_pth),
		.line_above_high(above_high), .manual_reset_n(manual_n),
		.watchdog_kick_input(kick), .kick_driven(kick_driven), .reset_line_in(line_in),
		.reset_line_out(), .reset_line_oe(line_oe), .reset_n_out(rst_lo),
		.reset_out(rst_hi), .pullup_en(pullup_en));
	host_model i_host_model (.clk_sys(clk_sys), .dev_oe(line_oe), .host_pull(host_pull),
		.pullup_en(pullup_en), .line_in(line_in), .above_pth(above_pth),
		.above_high(above_high));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rng(input int v, input int lo);
		chk({31'h0, v >= lo && v <= lo + 8}, 32'h1);
	endtask
	task automatic idle(input int c);
		repeat (c) @(negedge clk_sys);
	endtask
	// Cycles until the reset output reaches a level
	task automatic wait_rst(input logic lvl, output int cnt);
		cnt = 0;
		while (rst_lo !== lvl && cnt < 2000) begin
			@(negedge clk_sys);
			cnt++;
		end
	endtask
	task automatic t_manual;
		manual_n = 1'b0;
		idle(3);
		manual_n = 1'b1;
		idle(10);
		chk(rst_lo, 1'b1);
		manual_n = 1'b0;
		idle(20);
		chk({rst_lo, rst_hi}, 2'b01);
		manual_n = 1'b1;
		wait_rst(1'b1, n);
		rng(n, HOLD);
	endtask
	task automatic t_uv;
		undervoltage = 1'b1;
		idle(40);
		chk(rst_lo, 1'b0);
		undervoltage = 1'b0;
		wait_rst(1'b1, n);
		rng(n, HOLD);
	endtask
	task automatic t_kick;
		kick_driven = 1'b1;
		repeat (4) begin
			idle(150);
			kick = !kick;
		end
		chk(rst_lo, 1'b1);
		wait_rst(1'b0, n);
		rng(n, KICK);
		wait_rst(1'b1, n);
		rng(n, HOLD);
		idle(KICK - 10);
		chk(rst_lo, 1'b1);
		kick_driven = 1'b0;
		kick = !kick;
		idle(3 * KICK);
		chk(rst_lo, 1'b1);
	endtask
	task automatic t_line;
		host_pull = 1'b1;
		idle(4);
		host_pull = 1'b0;
		idle(2);
		chk(line_in, 1'b0);
		wait_rst(1'b1, n);
		rng(n, HOLD - 4);
		seen = 1'b0;
		repeat (20) begin
			idle(1);
			seen = seen | pullup_en;
		end
		chk({seen, pullup_en, line_in}, 3'b101);
	endtask
	task automatic summarize;
		if (fails == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Clock
	initial begin
		forever #10 clk_sys = !clk_sys;
	end
	// Watchdog against a hang
	initial begin
		#200000;
		fails++;
		summarize();
	end
	// Main sequence
	initial begin
		idle(8);
		rst_n = 1'b1;
		wait_rst(1'b1, n);
		rng(n, HOLD);
		t_manual();
		t_uv();
		t_kick();
		t_line();
		summarize();
	end
endmodule
